// ===== rtl/evf_regs.svh
// Holds the constants of the exception vector and fill unit.
// Assumes inclusion by the main module only.
//
// Function
// - Exception redirects fetch, saves return PC, pushes.
// - Nested miss, three-level scheme, vectors to 100.
// - Nested miss, four-level scheme, vectors to 180.
// - Misaligned 280, data miss 300, fault 380.
// - FP disabled 200, fetch fault 480, imiss 580.
// - Illegal opcodes vector to 400, privilege exempt.
// - Unimplemented 14/1C functions, extended IEEE illegal.
// - Machine check 500, reset or wakeup 780.
// - All interrupt kinds share entry 680.
// - Arithmetic trap 600, FP control write 700.
// - Barrier enabled: first entry write fires barrier.
// - Commit only on second entry write retire.
// - New entry visible after retire; nonzero hint hides hits in EVF_FILL_ENT1.
// - Fill matching existing key is ignored.
// - Page table load miss keeps fault registers.
// - Scoreboard [3:0] holds restarted loads, stores.
// - Scoreboard [7:4] writers wait for retire.
`ifndef EVF_REGS_SVH
`define EVF_REGS_SVH
////////////////////////////////////////////////////////////
// Entry offsets from the handler base
`define EVF_OFS_DMISS_NEST3  15'h0100
`define EVF_OFS_DMISS_NEST4  15'h0180
`define EVF_OFS_FP_DIS       15'h0200
`define EVF_OFS_MISALIGN     15'h0280
`define EVF_OFS_DMISS        15'h0300
`define EVF_OFS_DATA_ACCESS_FAULT_ENTRY       15'h0380
`define EVF_OFS_ILLEGAL      15'h0400
`define EVF_OFS_IFAULT       15'h0480
`define EVF_OFS_MACHINE_CHECK_ENTRY         15'h0500
`define EVF_OFS_IMISS        15'h0580
`define EVF_OFS_NUMERIC_TRAP_ENTRY        15'h0600
`define EVF_OFS_INTR         15'h0680
`define EVF_OFS_FPCW         15'h0700
`define EVF_OFS_RESET        15'h0780
////////////////////////////////////////////////////////////
// Base field position and handler mode flag in the PC
`define EVF_BASE_LSB         15
`define EVF_PC_PAL_BIT       64'h0000000000000001
// Opcode values
`define EVF_OP_ILL_LO        6'h01
`define EVF_OP_ILL_HI        6'h07
`define EVF_OP_PRIV_A        6'h19
`define EVF_OP_PRIV_B        6'h1b
`define EVF_OP_PRIV_C        6'h1d
`define EVF_OP_PRIV_D        6'h1e
`define EVF_OP_PRIV_E        6'h1f
`define EVF_OP_FUNC_A        6'h14
`define EVF_OP_FUNC_B        6'h1c
// Scoreboard groups
`define EVF_SB_RD_MASK       8'h0f
`define EVF_SB_WR_MASK       8'hf0
// Reset values
`define EVF_BASE_RST         64'h0000000000000000
`endif

// ===== rtl/evf_pkg.sv
// Holds the types of the exception vector and fill unit.
// Assumes the constants header is on the include path.
package evf_pkg;
   // Fill sequencer states
   typedef enum logic [2:0] {
      EVF_FILL_IDLE,
      EVF_FILL_KEY0,
      EVF_FILL_KEY1,
      EVF_FILL_ENT0,
      EVF_FILL_ENT1
   } evf_fill_type;
endpackage : evf_pkg

// ===== rtl/evf_fill_if.sv
// Carries a fill request between the main unit and the buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface evf_fill_if #(parameter int KW = 52, parameter int EW = 64);
   logic          wr;       // Commit pulse
   logic [KW-1:0] key;      // Translation key
   logic [EW-1:0] entry;    // Translation entry
   logic          hit;      // Key already present
   modport src (output wr, output key, output entry, input hit);
   modport dst (input wr, input key, input entry, output hit);
endinterface : evf_fill_if
`default_nettype wire

// ===== rtl/evf_xlate_buf.sv
// Holds the data translation buffer entries.
// Assumes commits come one at a time from the fill sequencer.
`timescale 1ns/1ps
`default_nettype none
module evf_xlate_buf
   import evf_pkg::*;
#(
   parameter int KW = 52,
   parameter int EW = 64,
   parameter int N  = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill port
   evf_fill_if.dst  fill,
   // Lookup port
   input wire logic [KW-1:0] look_key,
   output logic              look_hit
);
   logic [KW-1:0]        key_q [N];   // Stored keys
   logic [EW-1:0]        ent_q [N];   // Stored entries
   logic [N-1:0]         val_q;       // Valid bits
   logic [$clog2(N)-1:0] ptr_q;       // Round robin victim
   logic [N-1:0]         fhit;        // Fill key matches
   logic [N-1:0]         lhit;        // Lookup key matches

   // Match both keys against every slot
   always_comb begin
      for (int i = 0; i < N; i++) begin
         fhit[i] = val_q[i] && (key_q[i] == fill.key);
         lhit[i] = val_q[i] && (key_q[i] == look_key);
      end
   end
   assign fill.hit = |fhit;
   assign look_hit = |lhit;

   // Write a new slot only when the key is absent
   always_ff @(posedge clk) begin
      if (rst) begin
         val_q <= '0;
         ptr_q <= '0;
      end else if (fill.wr && !fill.hit) begin
         key_q[ptr_q] <= fill.key;
         ent_q[ptr_q] <= fill.entry;
         val_q[ptr_q] <= 1'b1;
         ptr_q        <= ptr_q + 1'b1;
      end
   end
endmodule : evf_xlate_buf
`default_nettype wire

// ===== rtl/evf_unit.sv
// Holds the exception vector and translation fill unit top.
// Assumes the pipeline reports events and retires in order.
//
// Configuration arrives on plain ports; no register addresses, no address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "evf_regs.svh"
module evf_unit
   import evf_pkg::*;
#(
   parameter int KW = 52,
   parameter int EW = 64,
   parameter int N  = 8,
   parameter int GHL = 5,
   parameter int GHW = 2
) (
   // Clock and reset
   input wire logic          clk,
   input wire logic          rst,
   // Configuration
   input wire logic [63:0]   handler_base_reg,
   input wire logic          fill_barrier_enable,
   input wire logic          privileged_ops_enable,
   input wire logic          handler_privileged_mode,
   input wire logic          walk_four_level,
   // Exception conditions
   input wire logic          ev_reset_wakeup,
   input wire logic          ev_machine_check,
   input wire logic          ev_interrupt,
   input wire logic          ev_async_system_trap,
   input wire logic          ev_fetch_fault,
   input wire logic          ev_imiss,
   input wire logic          ev_fp_disabled,
   input wire logic          ev_opcode_valid,
   input wire logic [5:0]    ev_opcode,
   input wire logic          ev_func_unimpl,
   input wire logic          ev_ext_ieee,
   input wire logic          ev_misalign,
   input wire logic          ev_dmiss,
   input wire logic          ev_dmiss_on_pte,
   input wire logic          ev_data_access_fault_entry,
   input wire logic          ev_numeric_trap_entry,
   input wire logic          ev_fp_control_write,
   input wire logic [63:0]   ev_pc,
   input wire logic [63:0]   ev_addr,
   input wire logic [15:0]   ev_info,
   // Translation writes from the handler
   input wire logic          key_write_first,
   input wire logic          key_write_second,
   input wire logic          entry_write_first,
   input wire logic          entry_write_second,
   input wire logic [63:0]   xlate_wdata,
   input wire logic          entry_second_retire,
   input wire logic          fill_abort,
   // Scoreboard
   input wire logic [7:0]    sb_set,
   input wire logic [7:0]    sb_clear,
   // Lookup
   input wire logic [KW-1:0] look_key,
   // Redirect outputs
   output logic              redirect,
   output logic [63:0]       redirect_pc,
   output logic [63:0]       fault_return_pc,
   output logic              ras_push,
   output logic [63:0]       ras_data,
   output logic [63:0]       faulting_address_reg,
   output logic [15:0]       memory_fault_info_reg,
   // Ordering outputs
   output logic              fill_light_barrier,
   output logic              mem_stall,
   output logic              sb_write_stall,
   output logic              entry_visible,
   output logic [7:0]        scoreboard
);
   ////////////////////////////////////////////////////////////
   // Decode of the illegal opcode conditions
   function automatic logic is_priv_op(input logic [5:0] op);
      is_priv_op = (op == `EVF_OP_PRIV_A) || (op == `EVF_OP_PRIV_B) ||
                   (op == `EVF_OP_PRIV_C) || (op == `EVF_OP_PRIV_D) ||
                   (op == `EVF_OP_PRIV_E);
   endfunction : is_priv_op

   wire logic op_reserved;  // Opcodes one through seven
   wire logic op_priv_bad;  // Privileged op outside enabled handler mode
   wire logic op_func_bad;  // Unimplemented function code
   wire logic illegal;      // Any illegal opcode cause
   assign op_reserved = (ev_opcode >= `EVF_OP_ILL_LO) && (ev_opcode <= `EVF_OP_ILL_HI);
   assign op_priv_bad = is_priv_op(ev_opcode) &&
                        !(handler_privileged_mode && privileged_ops_enable);
   assign op_func_bad = ev_func_unimpl &&
                        ((ev_opcode == `EVF_OP_FUNC_A) || (ev_opcode == `EVF_OP_FUNC_B));
   assign illegal = ev_opcode_valid &&
                    (op_reserved || op_priv_bad || op_func_bad || ev_ext_ieee);

   ////////////////////////////////////////////////////////////
   // Fixed priority entry selection
   wire logic        any_ev;   // Some exception pending
   wire logic [14:0] ofs;      // Selected entry offset
   wire logic        data_ev;  // Updates fault registers
   wire logic        intr_any; // Shared interrupt entry
   assign intr_any = ev_interrupt || ev_async_system_trap;
   assign ofs = ev_reset_wakeup     ? `EVF_OFS_RESET :
                ev_machine_check    ? `EVF_OFS_MACHINE_CHECK_ENTRY :
                intr_any            ? `EVF_OFS_INTR :
                ev_fetch_fault      ? `EVF_OFS_IFAULT :
                ev_imiss            ? `EVF_OFS_IMISS :
                illegal             ? `EVF_OFS_ILLEGAL :
                ev_fp_disabled      ? `EVF_OFS_FP_DIS :
                ev_dmiss_on_pte     ? (walk_four_level ? `EVF_OFS_DMISS_NEST4
                                                       : `EVF_OFS_DMISS_NEST3) :
                ev_misalign         ? `EVF_OFS_MISALIGN :
                ev_data_access_fault_entry           ? `EVF_OFS_DATA_ACCESS_FAULT_ENTRY :
                ev_dmiss            ? `EVF_OFS_DMISS :
                ev_numeric_trap_entry            ? `EVF_OFS_NUMERIC_TRAP_ENTRY :
                                      `EVF_OFS_FPCW;
   assign any_ev = ev_reset_wakeup || ev_machine_check || intr_any || ev_fetch_fault ||
                   ev_imiss || illegal || ev_fp_disabled || ev_dmiss_on_pte ||
                   ev_misalign || ev_data_access_fault_entry || ev_dmiss || ev_numeric_trap_entry || ev_fp_control_write;
   // Fault registers held when the page table load itself misses
   assign data_ev = !ev_dmiss_on_pte && (ev_misalign || ev_data_access_fault_entry || ev_dmiss);

   wire logic [63:0] vec_pc;  // Base plus offset, handler mode
   assign vec_pc = {handler_base_reg[63:`EVF_BASE_LSB], ofs} | `EVF_PC_PAL_BIT;

   // Redirect fetch and capture return PC
   always_ff @(posedge clk) begin
      if (rst) begin
         redirect        <= 1'b0;
         redirect_pc     <= `EVF_BASE_RST;
         fault_return_pc <= '0;
         ras_push        <= 1'b0;
         ras_data        <= '0;
      end else begin
         redirect <= any_ev;
         ras_push <= any_ev;
         if (any_ev) begin
            redirect_pc     <= vec_pc;
            fault_return_pc <= ev_pc;
            ras_data        <= ev_pc;
         end
      end
   end

   // Fault info capture
   always_ff @(posedge clk) begin
      if (rst) begin
         faulting_address_reg  <= '0;
         memory_fault_info_reg <= '0;
      end else if (data_ev && !ev_reset_wakeup && !ev_machine_check) begin
         faulting_address_reg  <= ev_addr;
         memory_fault_info_reg <= ev_info;
      end
   end

   ////////////////////////////////////////////////////////////
   // Fill sequencer: collects writes, commits on retire
   evf_fill_type     st_q, st_d;   // Sequencer state
   logic [KW-1:0]    key_q;        // Pending key
   logic [EW-1:0]    ent_q;        // Pending entry
   logic             pend_vis_q;   // Nonzero hint entry pending
   wire logic        commit;       // Retire of second entry write
   wire logic        tb_hit;       // Look key in buffer

   evf_fill_if #(.KW(KW), .EW(EW)) fif ();
   assign commit    = entry_second_retire && (st_q == EVF_FILL_ENT1);
   assign fif.wr    = commit;
   assign fif.key   = key_q;
   assign fif.entry = ent_q;

   // Next state; interim writes are only staged, never committed
   always_comb begin
      st_d = st_q;
      case (st_q)
         EVF_FILL_IDLE: if (key_write_first)    st_d = EVF_FILL_KEY0;
         EVF_FILL_KEY0: if (key_write_second)   st_d = EVF_FILL_KEY1;
         EVF_FILL_KEY1: if (entry_write_first)  st_d = EVF_FILL_ENT0;
         EVF_FILL_ENT0: if (entry_write_second) st_d = EVF_FILL_ENT1;
         EVF_FILL_ENT1: if (commit)             st_d = EVF_FILL_IDLE;
         default:                               st_d = EVF_FILL_IDLE;
      endcase
      if (fill_abort) begin
         st_d = EVF_FILL_IDLE; // Handler relies on all-or-none
      end
   end

   // State and staged key and entry
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q       <= EVF_FILL_IDLE;
         key_q      <= '0;
         ent_q      <= '0;
         pend_vis_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (key_write_first) begin
            key_q <= xlate_wdata[63:64-KW];
         end
         if (entry_write_first) begin
            ent_q      <= xlate_wdata[EW-1:0];
            pend_vis_q <= |xlate_wdata[GHL+GHW-1:GHL];
         end
         if (commit || fill_abort) begin
            pend_vis_q <= 1'b0;
         end
      end
   end

   evf_xlate_buf #(.KW(KW), .EW(EW), .N(N)) u_buf (
      .clk      (clk),
      .rst      (rst),
      .fill     (fif.dst),
      .look_key (look_key),
      .look_hit (tb_hit)
   );

   ////////////////////////////////////////////////////////////
   // Scoreboard; a set beats a clear in the same cycle
   logic [7:0] sb_q;  // Outstanding buffer writers
   always_ff @(posedge clk) begin
      if (rst) begin
         sb_q <= '0;
      end else begin
         sb_q <= (sb_q & ~sb_clear) | sb_set;
      end
   end

   // Barrier, stalls and visibility
   always_ff @(posedge clk) begin
      if (rst) begin
         fill_light_barrier <= 1'b0;
         mem_stall          <= 1'b0;
         sb_write_stall     <= 1'b0;
         entry_visible      <= 1'b0;
         scoreboard         <= '0;
      end else begin
         fill_light_barrier <= fill_barrier_enable && entry_write_first;
         mem_stall          <= |(((sb_q & ~sb_clear) | sb_set) & `EVF_SB_RD_MASK);
         sb_write_stall     <= |(((sb_q & ~sb_clear) | sb_set) & `EVF_SB_WR_MASK);
         entry_visible      <= tb_hit && !(pend_vis_q && (st_q == EVF_FILL_ENT1));
         scoreboard         <= (sb_q & ~sb_clear) | sb_set;
      end
   end
endmodule : evf_unit
`default_nettype wire

// ===== sim/evf_pipe_model.sv
// Pipeline and handler model issuing the translation writes of one fill.
// Assumes the unit's clock; a fill starts on a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none
module evf_pipe_model (
   // Clock and control
   input wire logic        clk,
   input wire logic        go,
   input wire logic        slow,
   // Fill content
   input wire logic [63:0] key,
   input wire logic [63:0] ent,
   // Write pulses toward the unit
   output logic            busy,
   output logic            kw1, kw2, ew1, ew2, ret,
   output logic [63:0]     wdata
);
   logic [4:0]  p   = 5'h00;  // Pulses of this cycle
   logic [2:0]  st  = 3'd0;   // Fill step
   logic        gap = 1'b0;   // Idle slot when slow
   logic [63:0] wd  = 64'h0;  // Data beside a pulse
   assign {kw1, kw2, ew1, ew2, ret} = p;
   assign busy  = (st != 3'd0);
   assign wdata = wd;
   ////////////////////////////////////////////////////////////
   // All four writes then the retire, never a part of them
   always @(posedge clk) begin
      p   <= 5'h00;
      gap <= ~gap & slow;
      wd  <= ~wd;  // Unqualified data never keeps its value
      if (go) begin
         st <= 3'd1;
      end else if (busy && !gap) begin
         p  <= 5'h10 >> (st - 3'd1);
         wd <= (st < 3'd3) ? key : ent;
         st <= (st == 3'd5) ? 3'd0 : st + 3'd1;
      end
   end
endmodule : evf_pipe_model
`default_nettype wire

// ===== sim/evf_unit_checker.sv
// Concurrent checks on the ports of the exception vector unit.
// Assumes binding to the unit's top module by port name.
`timescale 1ns/1ps
`default_nettype none
module evf_unit_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Configuration and causes
   input wire logic [63:0] handler_base_reg,
   input wire logic        fill_barrier_enable,
   input wire logic        ev_reset_wakeup, ev_machine_check, ev_dmiss, ev_dmiss_on_pte,
   input wire logic        entry_write_first,
   // Observed outputs
   input wire logic        redirect, ras_push, fill_light_barrier, mem_stall, sb_write_stall,
   input wire logic [63:0] redirect_pc, fault_return_pc, ras_data, faulting_address_reg,
   input wire logic [15:0] memory_fault_info_reg,
   input wire logic [7:0]  scoreboard
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Causes that always redirect
   sequence ev_taken;
      ev_dmiss || ev_machine_check;
   endsequence
   // First entry write and the slot after it
   sequence entry_issue;
      entry_write_first ##1 1'b1;
   endsequence
   redir_after_ev_a:
      assert property (ev_taken |=> redirect && ras_push) else $error("no redirect after event");
   ras_copy_a:
      assert property (redirect |-> ras_data == fault_return_pc && redirect_pc[0] &&
         redirect_pc[63:15] == handler_base_reg[63:15]) else $error("bad return or base");
   reset_entry_a:
      assert property (ev_reset_wakeup |=> redirect_pc[14:0] == 15'h0781) else $error("bad reset entry");
   machine_check_entry_entry_a:
      assert property (ev_machine_check && !ev_reset_wakeup |=> redirect_pc[14:0] == 15'h0501)
         else $error("bad machine check entry");
   nested_keeps_a:
      assert property (ev_dmiss_on_pte |=> $stable(faulting_address_reg) && $stable(memory_fault_info_reg))
         else $error("fault regs overwritten");
   barrier_pulse_a:
      assert property (entry_issue |-> fill_light_barrier == $past(fill_barrier_enable))
         else $error("barrier wrong after entry write");
   barrier_cause_a:
      assert property (fill_light_barrier |-> $past(entry_write_first)) else $error("stray barrier");
   // Stalls and the scoreboard copy leave the same edge from the same value
   read_stall_a:
      assert property (mem_stall == |(scoreboard & 8'h0f)) else $error("bad load stall");
   write_stall_a:
      assert property (sb_write_stall == |(scoreboard & 8'hf0)) else $error("bad write stall");
endmodule : evf_unit_checker
bind evf_unit evf_unit_checker i_evf_unit_checker (.clk, .rst, .handler_base_reg, .fill_barrier_enable,
   .ev_reset_wakeup, .ev_machine_check, .ev_dmiss, .ev_dmiss_on_pte, .entry_write_first, .redirect,
   .ras_push, .fill_light_barrier, .mem_stall, .sb_write_stall, .redirect_pc, .fault_return_pc,
   .ras_data, .faulting_address_reg, .memory_fault_info_reg, .scoreboard);
`default_nettype wire

// ===== sim/evf_unit_test.sv
// Self-checking bench of the exception vector and fill unit.
// Assumes the pipeline model drives all translation writes.
`timescale 1ns/1ps
`default_nettype none
module evf_unit_test;
   // Stimulus
   logic        clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0, fbe = 1'b0;
   logic        priv_en = 1'b0, priv_md = 1'b0, walk = 1'b0, abort = 1'b0;
   logic [15:0] ev = 16'h0000, info = 16'h0000;
   logic [5:0]  op = 6'h00;
   logic [63:0] pc = 64'h0, addr = 64'h0, key = 64'h0, ent = 64'h0;
   logic [7:0]  sb_set = 8'h00, sb_clr = 8'h00;
   logic [51:0] look = 52'h0;
   // Observation
   logic        busy, kw1, kw2, ew1, ew2, ret, redirect, ras_push, barrier, mem_stall, wr_stall, vis;
   logic [63:0] wdata, rpc, frpc, ras_data, fa;
   logic [15:0] fi;
   logic [7:0]  sb;
   int          mismatches = 0, num_checks = 0;
   localparam logic [63:0] base = 64'h0000_1234_5678_8000;
   always #2.5 clk = ~clk;
   evf_unit i_evf_unit (.clk, .rst, .handler_base_reg(base), .fill_barrier_enable(fbe),
      .privileged_ops_enable(priv_en), .handler_privileged_mode(priv_md), .walk_four_level(walk),
      .ev_reset_wakeup(ev[0]), .ev_machine_check(ev[1]), .ev_interrupt(ev[2]), .ev_async_system_trap(ev[3]),
      .ev_fetch_fault(ev[4]), .ev_imiss(ev[5]), .ev_fp_disabled(ev[6]), .ev_misalign(ev[7]),
      .ev_dmiss(ev[8]), .ev_dmiss_on_pte(ev[9]), .ev_data_access_fault_entry(ev[10]), .ev_numeric_trap_entry(ev[11]),
      .ev_fp_control_write(ev[12]), .ev_opcode_valid(ev[13]), .ev_opcode(op), .ev_func_unimpl(ev[14]),
      .ev_ext_ieee(ev[15]), .ev_pc(pc), .ev_addr(addr), .ev_info(info), .key_write_first(kw1),
      .key_write_second(kw2), .entry_write_first(ew1), .entry_write_second(ew2), .xlate_wdata(wdata),
      .entry_second_retire(ret), .fill_abort(abort), .sb_set, .sb_clear(sb_clr), .look_key(look),
      .redirect, .redirect_pc(rpc), .fault_return_pc(frpc), .ras_push, .ras_data,
      .faulting_address_reg(fa), .memory_fault_info_reg(fi), .fill_light_barrier(barrier), .mem_stall,
      .sb_write_stall(wr_stall), .entry_visible(vis), .scoreboard(sb));
   evf_pipe_model i_evf_pipe_model (.clk, .go, .slow, .key, .ent, .busy, .kw1, .kw2, .ew1, .ew2, .ret,
      .wdata);
   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Counts and verdict
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   // One event set for a cycle, config {walk, mode, enable}
   task automatic do_ev(logic [15:0] e, logic [5:0] o, logic [2:0] c, logic h, logic [14:0] f);
      @(posedge clk);
      {walk, priv_md, priv_en} <= c;
      ev <= e;
      op <= o;
      pc <= pc + 64'h40;
      addr <= pc + 64'h40;
      info <= pc[15:0] + 16'h40;
      @(posedge clk);
      ev <= 16'h0000;
      #1 check("redirect", redirect, h);
      if (h) begin
         check("redirect_pc", rpc, {base[63:15], f} | 64'h1);
         check("return_pc", frpc, pc);
         check("ras_push", ras_push, 1'b1);
         check("ras_data", ras_data, pc);
      end
      @(posedge clk);
      #1 check("one_redirect", redirect, 1'b0);
   endtask : do_ev
   // Every entry but illegal, priority pairs, fault register updates
   task automatic t_vectors();
      logic [15:0] evs [16] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040,
         16'h0080, 16'h0400, 16'h0100, 16'h0300, 16'h0300, 16'h0800, 16'h1000, 16'h0003, 16'h1c00};
      logic [14:0] ofs [16] = '{15'h0780, 15'h0500, 15'h0680, 15'h0680, 15'h0480, 15'h0580, 15'h0200,
         15'h0280, 15'h0380, 15'h0300, 15'h0100, 15'h0180, 15'h0600, 15'h0700, 15'h0780, 15'h0380};
      logic [63:0] la = 64'h0;
      for (int i = 0; i < 16; i++) begin
         do_ev(evs[i], 6'h00, {i == 11, 2'b00}, 1'b1, ofs[i]);
         if (i inside {7, 8, 9, 15}) la = pc;
         check("fault_addr", fa, la);
         check("fault_info", fi, la[15:0]);
      end
      $display("vectors done");
   endtask : t_vectors
   // Illegal opcodes and the privileged exemption
   task automatic t_opcodes();
      logic [5:0] ill [12] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h19, 6'h1b, 6'h1d,
         6'h1e, 6'h1f};
      for (int i = 0; i < 12; i++) begin
         do_ev(16'h2000, ill[i], 3'b000, 1'b1, 15'h0400);
         if (i > 6) begin
            do_ev(16'h2000, ill[i], 3'b011, 1'b0, 15'h0000);
            do_ev(16'h2000, ill[i], 3'b010, 1'b1, 15'h0400);
            do_ev(16'h2000, ill[i], 3'b001, 1'b1, 15'h0400);
         end
      end
      do_ev(16'h6000, 6'h14, 3'b000, 1'b1, 15'h0400);
      do_ev(16'h6000, 6'h1c, 3'b000, 1'b1, 15'h0400);
      do_ev(16'ha000, 6'h16, 3'b000, 1'b1, 15'h0400);
      do_ev(16'h2000, 6'h10, 3'b000, 1'b0, 15'h0000);
      $display("opcodes done");
   endtask : t_opcodes
   // One fill: barrier count, hidden until retire, then visible
   task automatic do_fill(logic [51:0] k, logic [1:0] gh, logic s, logic b, logic fresh);
      logic [63:0] nb = 64'h0;
      @(posedge clk);
      key <= {k, 12'h000};
      ent <= {57'h0, gh, 5'h00};
      {slow, fbe, go} <= {s, b, 1'b1};
      look <= k;
      @(posedge clk);
      go <= 1'b0;
      for (int i = 0; i < 30 && (i < 2 || busy); i++) begin
         @(posedge clk);
         #1 nb = nb + barrier;
         if (ret && fresh) check("early_visible", vis, 1'b0);
      end
      repeat (3) @(posedge clk);
      #1 check("barrier_count", nb, b);
      check("visible", vis, 1'b1);
   endtask : do_fill
   // Fills with both hints, both speeds, then a repeated key
   task automatic t_fill();
      do_fill(52'ha5a5, 2'b11, 1'b1, 1'b1, 1'b1);
      do_fill(52'h5a5a, 2'b00, 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 10; i++) do_fill((i == 8) ? 52'h100 : 52'h100 + 52'(i - int'(i == 9)), 2'b00,
         1'b0, 1'b1, i != 8);
      @(posedge clk) look <= 52'h100;
      repeat (3) @(posedge clk);
      #1 check("dup_evicted", vis, 1'b0);
      @(posedge clk) look <= 52'h101;
      repeat (3) @(posedge clk);
      #1 check("next_kept", vis, 1'b1);
      $display("fill done");
   endtask : t_fill
   // Scoreboard groups and their stalls
   task automatic t_score();
      @(posedge clk) sb_set <= 8'h81;
      @(posedge clk) sb_set <= 8'h00;
      @(posedge clk);
      #1 check("sb_set", {sb, mem_stall, wr_stall}, {8'h81, 2'b11});
      @(posedge clk) sb_clr <= 8'h01;
      @(posedge clk) sb_clr <= 8'h80;
      #1 check("sb_clr", {sb, mem_stall, wr_stall}, {8'h80, 2'b01});
      @(posedge clk) sb_clr <= 8'h00;
      #1 check("sb_idle", {sb, mem_stall, wr_stall}, {8'h00, 2'b00});
      // Set and clear of one bit in one cycle: the set wins
      @(posedge clk) {sb_set, sb_clr} <= {8'h02, 8'h02};
      @(posedge clk) {sb_set, sb_clr} <= 16'h0000;
      #1 check("sb_both", {sb, mem_stall, wr_stall}, {8'h02, 2'b10});
      $display("scoreboard done");
   endtask : t_score
   // A fill dropped after its first key write never commits
   task automatic t_abort();
      @(posedge clk);
      key  <= {52'h200, 12'h000};
      look <= 52'h200;
      go   <= 1'b1;
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
      @(posedge clk) abort <= 1'b1;
      @(posedge clk) abort <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check("abort_dropped", vis, 1'b0);
      $display("abort done");
   endtask : t_abort
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_vectors();
      t_opcodes();
      t_fill();
      t_abort();
      t_score();
      final_report();
   end
   // Watchdog, some sixty times the expected run
   initial begin
      #100000;
      mismatches++;
      final_report();
   end
endmodule : evf_unit_test
`default_nettype wire
